/* adsc_pkg.sv */
// Constants shared by the converter sequence controller files.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package adsc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADSC_OFS_TIMING = 8'h00;
  localparam logic [7:0] ADSC_OFS_SEQ = 8'h04;
  localparam logic [7:0] ADSC_OFS_STAT = 8'h08;
  localparam logic [7:0] ADSC_OFS_CFG = 8'h0C;
  localparam logic [7:0] ADSC_OFS_RES_BASE = 8'h20;
  localparam logic [7:0] ADSC_OFS_RES_LAST = 8'h3C;
  // ==========================================================
  // Field positions
  localparam int ADSC_SEQ_EIGHT_BIT = 6;
  localparam int ADSC_SEQ_CONT_BIT = 5;
  localparam int ADSC_SEQ_SWEEP_BIT = 4;
  localparam int ADSC_SEQ_INTERNAL_BIT = 3;
  localparam int ADSC_CFG_FIFO_BIT = 0;
  localparam int ADSC_CFG_QUICK_BIT = 1;
  localparam int ADSC_CFG_ONE_BIT = 2;
  localparam int ADSC_STAT_DONE_BIT = 15;
  localparam int ADSC_STAT_MISMATCH_BIT = 14;
  // ==========================================================
  // Reset values
  localparam logic [7:0] ADSC_TIMING_RST = 8'h01;
  localparam logic [7:0] ADSC_SEQ_RST = 8'h00;
  localparam logic [7:0] ADSC_CFG_RST = 8'h00;
  // ==========================================================
  // Sequence lengths and special channels
  localparam logic [3:0] ADSC_LEN_FOUR = 4'h4;
  localparam logic [3:0] ADSC_LEN_ONE = 4'h1;
  localparam logic [3:0] ADSC_LEN_EIGHT = 4'h8;
  localparam logic [2:0] ADSC_SPC_HIGH = 3'h4;
  localparam logic [2:0] ADSC_SPC_LOW = 3'h5;
  localparam logic [2:0] ADSC_SPC_MID = 3'h6;
  localparam logic [7:0] ADSC_EXP_HIGH = 8'hFF;
  localparam logic [7:0] ADSC_EXP_LOW = 8'h00;
  localparam logic [7:0] ADSC_EXP_MID = 8'h7F;
  // ==========================================================
  // States
  typedef enum logic [1:0]
  {
    ADSC_IDLE = 2'b00,
    ADSC_WAIT = 2'b01,
    ADSC_CONV = 2'b10
  } adsc_state_t;
endpackage

/* adsc_result_mem.sv */
// Result register file: one write port, one registered read port.
// Assumes writes and reads on the same clock edge never need bypass.
`timescale 1ns/1ps
module adsc_result_mem
#(
  parameter int W = 10,
  parameter int D = 8,
  parameter int AW = 3
)
(
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

/* adsc_tick_div.sv */
// Conversion pacing divider: one-cycle tick every (prescale+1)*2 clocks.
// Assumes restart_i realigns the count when a sequence begins.
`timescale 1ns/1ps
module adsc_tick_div
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic restart_i,
  input wire logic [4:0] prescale_i,
  output logic tick_o
);
  logic [5:0] cnt_r;
  logic [5:0] top;

  assign top = {prescale_i, 1'b1};

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || restart_i)
    begin
      cnt_r <= 6'h00;
      tick_o <= 1'b0;
    end
    else if (cnt_r >= top)
    begin
      cnt_r <= 6'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 6'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

/* adsc_ctrl.sv */
// Sequence controller for an eight-input converter, Wishbone slave.
// Assumes a converter core that takes a start pulse and answers
// with conv_done_i and a 10-bit result; only one clock domain.
// Contract
// [R1] Single mode: one sequence, flag, then idle.
// [R2] Continuous mode: flag, restart identical sequence.
// [R3] Idle performs no conversions until started.
// [R4] Writing either control register starts sequence.
// [R5] Software stops, reprograms, restarts to change mode.
// [R6] Single-channel mode converts the selected channel.
// [R7] Sweep mode increments channel each conversion.
// [R8] Channel code wraps seven to zero.
// [R9] Internal select converts special reference channels.
// [R10] Special codes: high, low, midpoint; others reserved.
// [R11] Expected eight-bit codes FF, 00, 7F.
// [R12] Channel code selects input by binary value.
// [R13] Result n holds start code plus n.
// [R14] Software picks valid special sweep start code.
// [R15] Software clears one-length bit for four sweep.
// [R16] Single channel: four, eight, or one conversion.
// [R17] Done flag set after every sequence.
// [R18] Without quick clear, only start clears flag.
// [R19] Quick clear: result read clears flag.
// [R20] Result pointer zeroed at start outside FIFO.
// [R21] FIFO pointer keeps advancing, wraps at seven.
// [R22] Status register ignores software writes.
// [R23] Length bits select eight, one or four.
// [R24] Start write aborts running sequence.
// [R25] FIFO results continue across sequences.
// [R26] Pointer advances per conversion; done event pulse.
// [R27] Channel equals start plus index, three bits.
`timescale 1ns/1ps
module adsc_ctrl
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic [2:0] conv_chan_o,
  output logic conv_internal_o,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  output logic seq_done_o,
  output logic busy_o
);
  import adsc_pkg::*;

  // ==========================================================
  // Decoding helpers
  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= ADSC_OFS_RES_BASE) && (a <= ADSC_OFS_RES_LAST)
      && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [3:0] seq_len(input logic eight, input logic one);
    if (eight)
      seq_len = ADSC_LEN_EIGHT;
    else if (one)
      seq_len = ADSC_LEN_ONE;
    else
      seq_len = ADSC_LEN_FOUR;
  endfunction

  function automatic logic [8:0] exp_code(input logic [2:0] c);
    if (c == ADSC_SPC_HIGH)
      exp_code = {1'b1, ADSC_EXP_HIGH};
    else if (c == ADSC_SPC_LOW)
      exp_code = {1'b1, ADSC_EXP_LOW};
    else if (c == ADSC_SPC_MID)
      exp_code = {1'b1, ADSC_EXP_MID};
    else
      exp_code = 9'h000;
  endfunction

  // ==========================================================
  // Registers and state
  logic [7:0] timing_r;
  logic [7:0] seq_r;
  logic [7:0] cfg_r;
  logic done_r;
  logic mismatch_r;
  logic [2:0] ptr_r;
  logic [3:0] idx_r;
  adsc_state_t state_r;
  logic phase_r;
  logic [9:0] mem_rd;
  logic tick;

  logic req;
  logic fire;
  logic wr_hit;
  logic start_wr;
  logic rd_res;
  logic conv_fin;
  logic seq_last;
  logic [3:0] len;
  logic [2:0] chan_nxt;
  logic fifo;
  logic quick;
  logic cont;
  logic [15:0] stat;
  logic [8:0] expect_v;

  assign fifo = cfg_r[ADSC_CFG_FIFO_BIT];
  assign quick = cfg_r[ADSC_CFG_QUICK_BIT];
  assign cont = seq_r[ADSC_SEQ_CONT_BIT];
  assign len = seq_len(seq_r[ADSC_SEQ_EIGHT_BIT], cfg_r[ADSC_CFG_ONE_BIT]); // [R23] [R16]
  // Sweep adds the index; the 3-bit sum wraps seven to zero by itself.
  assign chan_nxt = seq_r[ADSC_SEQ_SWEEP_BIT] ? 3'(seq_r[2:0] + idx_r[2:0]) // [R7] [R8] [R27]
    : seq_r[2:0]; // [R6] [R12]
  assign stat = {done_r, mismatch_r, 11'h000, ptr_r};
  assign expect_v = exp_code(conv_chan_o);

  // ==========================================================
  // Bus handshake: ack two cycles after the request appears so the
  // registered result memory has its data ready.
  assign req = wb_cyc_i && wb_stb_i;
  assign fire = req && wb_ack_o;
  assign wr_hit = fire && wb_we_i;
  assign start_wr = wr_hit
    && ((wb_adr_i == ADSC_OFS_TIMING) || (wb_adr_i == ADSC_OFS_SEQ)); // [R4]
  assign rd_res = fire && !wb_we_i && is_result(wb_adr_i);
  assign conv_fin = (state_r == ADSC_CONV) && conv_done_i && !start_wr;
  assign seq_last = conv_fin && (idx_r == (len - 4'h1));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      phase_r <= 1'b0;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      phase_r <= req && !phase_r && !wb_ack_o;
      wb_ack_o <= phase_r && req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (phase_r)
    begin
      if (wb_adr_i == ADSC_OFS_TIMING)
        wb_dat_o <= {24'h000000, timing_r};
      else if (wb_adr_i == ADSC_OFS_SEQ)
        wb_dat_o <= {24'h000000, seq_r};
      else if (wb_adr_i == ADSC_OFS_STAT)
        wb_dat_o <= {16'h0000, stat};
      else if (wb_adr_i == ADSC_OFS_CFG)
        wb_dat_o <= {24'h000000, cfg_r};
      else if (is_result(wb_adr_i))
        wb_dat_o <= {22'h0, mem_rd};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Control registers; status has no write path at all. [R22]
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      timing_r <= ADSC_TIMING_RST;
      seq_r <= ADSC_SEQ_RST;
      cfg_r <= ADSC_CFG_RST;
    end
    else if (wr_hit && wb_sel_i[0])
    begin
      if (wb_adr_i == ADSC_OFS_TIMING)
        timing_r <= wb_dat_i[7:0];
      else if (wb_adr_i == ADSC_OFS_SEQ)
        seq_r <= {1'b0, wb_dat_i[6:0]};
      else if (wb_adr_i == ADSC_OFS_CFG)
        cfg_r <= {5'h00, wb_dat_i[2:0]};
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ADSC_IDLE;
      idx_r <= 4'h0;
    end
    else if (start_wr)
    begin
      state_r <= ADSC_WAIT; // [R4] [R24]
      idx_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        ADSC_IDLE:
        begin
          state_r <= ADSC_IDLE; // [R3]
        end
        ADSC_WAIT:
        begin
          if (tick)
            state_r <= ADSC_CONV;
        end
        ADSC_CONV:
        begin
          if (seq_last)
          begin
            idx_r <= 4'h0;
            state_r <= cont ? ADSC_WAIT : ADSC_IDLE; // [R1] [R2]
          end
          else if (conv_fin)
          begin
            idx_r <= idx_r + 4'h1;
            state_r <= ADSC_WAIT;
          end
        end
        default:
        begin
          state_r <= ADSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
      conv_chan_o <= 3'h0;
      conv_internal_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      conv_abort_o <= start_wr && (state_r != ADSC_IDLE); // [R24]
      conv_start_o <= !start_wr && (state_r == ADSC_WAIT) && tick;
      busy_o <= start_wr || (state_r != ADSC_IDLE)
        && !(seq_last && !cont);
      if (!start_wr && (state_r == ADSC_WAIT) && tick)
      begin
        conv_chan_o <= chan_nxt; // [R27] [R10]
        conv_internal_o <= seq_r[ADSC_SEQ_INTERNAL_BIT]; // [R9]
      end
    end
  end

  // ==========================================================
  // Result pointer: zeroed at start and end of a normal sequence,
  // free running in FIFO mode.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ptr_r <= 3'h0;
    end
    else if (start_wr && !fifo)
    begin
      ptr_r <= 3'h0; // [R20]
    end
    else if (seq_last && !fifo)
    begin
      ptr_r <= 3'h0;
    end
    else if (conv_fin)
    begin
      ptr_r <= ptr_r + 3'h1; // [R26] [R21] [R25] [R13]
    end
  end

  // ==========================================================
  // Done flag: completion wins over a quick clear in the same cycle; a start write blocks completion and clears.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      done_r <= 1'b0;
      seq_done_o <= 1'b0;
    end
    else
    begin
      seq_done_o <= seq_last; // [R26]
      if (seq_last)
        done_r <= 1'b1; // [R17]
      else if (start_wr)
        done_r <= 1'b0; // [R18]
      else if (quick && rd_res)
        done_r <= 1'b0; // [R19]
    end
  end

  // A special conversion that misses its expected code flags the
  // reference path; reserved codes are never judged.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || start_wr)
    begin
      mismatch_r <= 1'b0;
    end
    else if (conv_fin && conv_internal_o && expect_v[8]
      && (conv_data_i[9:2] != expect_v[7:0]))
    begin
      mismatch_r <= 1'b1; // [R11]
    end
  end

  // ==========================================================
  // Submodules
  adsc_result_mem #(.W(10), .D(8), .AW(3)) u_mem
  (
    .clk_i(clk_i),
    .wr_en_i(conv_fin),
    .wr_addr_i(ptr_r),
    .wr_data_i(conv_data_i),
    .rd_addr_i(wb_adr_i[4:2]),
    .rd_data_o(mem_rd)
  );

  adsc_tick_div u_div
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(start_wr),
    .prescale_i(timing_r[4:0]),
    .tick_o(tick)
  );

  // ==========================================================
  // Assertions
  a_abort_on_start: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R24]
    start_wr && (state_r != ADSC_IDLE) |=> conv_abort_o && (state_r == ADSC_WAIT))
    else $error("running sequence not aborted");

  a_start_begins: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R4]
    start_wr |=> (state_r == ADSC_WAIT) && (idx_r == 4'h0))
    else $error("start write did not begin sequence");

  a_single_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R1]
    seq_last && !cont |=> (state_r == ADSC_IDLE) && done_r)
    else $error("single sequence did not end idle");

  a_cont_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R2]
    seq_last && cont |=> (state_r == ADSC_WAIT) && done_r && (idx_r == 4'h0))
    else $error("continuous sequence did not restart");

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R3]
    (state_r == ADSC_IDLE) && !start_wr |=> !conv_start_o)
    else $error("conversion started while idle");

  a_chan_formed: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R27]
    conv_start_o |-> conv_chan_o == (seq_r[ADSC_SEQ_SWEEP_BIT]
      ? 3'(seq_r[2:0] + idx_r[2:0]) : seq_r[2:0]))
    else $error("channel code wrong");

  a_done_event: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R26]
    seq_last |=> seq_done_o ##1 !seq_done_o)
    else $error("sequence done event wrong");

  a_ptr_step: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R26]
    conv_fin && !seq_last |=> ptr_r == 3'($past(ptr_r) + 3'h1))
    else $error("pointer did not advance");

  a_ptr_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R20]
    start_wr && !fifo |=> ptr_r == 3'h0)
    else $error("pointer not cleared at start");

  a_fifo_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R21]
    start_wr && fifo |=> $stable(ptr_r))
    else $error("pointer cleared in fifo mode");

  a_flag_start_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R18]
    start_wr |=> !done_r)
    else $error("start did not clear done flag");

  a_flag_quick_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R19]
    rd_res && quick && !seq_last |=> !done_r)
    else $error("result read did not clear done flag");

  a_flag_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R18]
    done_r && !quick && !start_wr |=> done_r)
    else $error("done flag cleared without start");

  a_status_ro: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R22]
    wr_hit && (wb_adr_i == ADSC_OFS_STAT) && (state_r == ADSC_IDLE)
    |=> $stable(done_r) && $stable(ptr_r))
    else $error("status changed by a write");

  a_len_eight: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R23]
    conv_fin && seq_r[ADSC_SEQ_EIGHT_BIT] && (idx_r == 4'h7) |-> seq_last)
    else $error("eight length not honoured");

  a_len_one: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R16]
    conv_fin && !seq_r[ADSC_SEQ_EIGHT_BIT] && cfg_r[ADSC_CFG_ONE_BIT] |-> seq_last)
    else $error("one length not honoured");
endmodule

/* adsc_core_model.sv */
// Behavioural model of the sample-and-hold and converter core.
// Assumes one-cycle start and abort pulses from the sequence controller.
`timescale 1ns/1ps
module adsc_core_model
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] lat_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [2:0] chan_i,
  input wire logic internal_i,
  output logic done_o,
  output logic [9:0] data_o
);
  logic [3:0] cnt_r;
  logic [9:0] res_r;

  // ==========================================================
  // Conversion timing
  // Between answers the data lines toggle, so a controller that
  // captures outside the done cycle is caught.
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (sys_rst_i || abort_i)
    begin
      cnt_r <= 4'h0;
      data_o <= 10'h155;
    end
    else if (start_i)
    begin
      cnt_r <= lat_i + 4'h1;
      data_o <= ~data_o;
      if (internal_i)
        res_r <= (chan_i == 3'h4) ? 10'h3FC : (chan_i == 3'h6) ? 10'h1FC : 10'h000;
      else
        res_r <= {2'b10, chan_i, 5'h05};
    end
    else if (cnt_r == 4'h1)
    begin
      cnt_r <= 4'h0;
      done_o <= 1'b1;
      data_o <= res_r;
    end
    else
    begin
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      data_o <= ~data_o;
    end
  end
endmodule

/* tb_adsc_ctrl.sv */
// Self-checking bench for the converter sequence controller.
// Assumes the core model answers each start lat_r+1 cycles after it samples the start pulse.
`timescale 1ns/1ps
module tb_adsc_ctrl;
  import adsc_pkg::*;
  typedef struct {logic [7:0] seq; logic [7:0] cfg; int len;} adsc_row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, conv_start_o, conv_abort_o, conv_internal_o, conv_done_i;
  logic seq_done_o, busy_o;
  logic [2:0] conv_chan_o;
  logic [9:0] conv_data_i;
  logic [3:0] lat_r = 4'h2;
  logic [3:0] starts[$];
  logic [31:0] q;
  int n_abort = 0;
  int n_fail = 0;
  int checks = 0;
  adsc_row_t rows[8] = '{'{8'h03, 8'h00, 4}, '{8'h45, 8'h00, 8}, '{8'h02, 8'h04, 1},
    '{8'h16, 8'h00, 4}, '{8'h53, 8'h00, 8}, '{8'h4C, 8'h00, 8}, '{8'h1D, 8'h04, 1},
    '{8'h0E, 8'h04, 1}};

  always #10 clk_i = ~clk_i;

  adsc_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
    .conv_chan_o(conv_chan_o), .conv_internal_o(conv_internal_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .seq_done_o(seq_done_o),
    .busy_o(busy_o));
  adsc_core_model core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lat_i(lat_r),
    .start_i(conv_start_o), .abort_i(conv_abort_o), .chan_i(conv_chan_o),
    .internal_i(conv_internal_o), .done_o(conv_done_i), .data_o(conv_data_i));

  // ==========================================================
  // Monitor
  // Sampling on the falling edge keeps it clear of the driver's edge.
  always @(negedge clk_i)
  begin
    if (conv_start_o === 1'b1)
      starts.push_back({conv_internal_o, conv_chan_o});
    if (conv_abort_o === 1'b1)
      n_abort++;
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk(32'(n < 50), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run_seq(input logic [7:0] s, input logic [7:0] c);
    xfer(1'b1, ADSC_OFS_CFG, {24'h0, c});
    n_abort = 0;
    xfer(1'b1, ADSC_OFS_SEQ, {24'h0, s});
    starts.delete();
  endtask

  task automatic wait_done(input int k);
    int n;
    int g;
    n = 0;
    g = 0;
    while (g < k && n < 2000)
    begin
      @(posedge clk_i);
      n++;
      if (seq_done_o === 1'b1)
        g++;
    end
    chk(32'(g), 32'(k));
  endtask

  function automatic logic [3:0] exp_code(input logic [7:0] s, input int j);
    return {s[3], s[4] ? s[2:0] + 3'(j) : s[2:0]};
  endfunction

  function automatic logic [31:0] exp_data(input logic [3:0] e);
    if (!e[3])
      return {22'h0, 2'b10, e[2:0], 5'h05};
    return (e[2:0] == ADSC_SPC_HIGH) ? {22'h0, ADSC_EXP_HIGH, 2'b00} :
      (e[2:0] == ADSC_SPC_MID) ? {22'h0, ADSC_EXP_MID, 2'b00} : {22'h0, ADSC_EXP_LOW, 2'b00};
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(1'b0, ADSC_OFS_TIMING, 32'h0);
    chk(q, {24'h0, ADSC_TIMING_RST});
    xfer(1'b0, ADSC_OFS_SEQ, 32'h0);
    chk(q, {24'h0, ADSC_SEQ_RST});
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(q, 32'h0);
    foreach (rows[i])
    begin
      run_seq(rows[i].seq, rows[i].cfg);
      xfer(1'b0, ADSC_OFS_STAT, 32'h0);
      chk(32'(q[15]), 32'h0);
      wait_done(1);
      chk(32'(starts.size()), 32'(rows[i].len));
      for (int j = 0; j < rows[i].len; j++)
      begin
        chk(32'(starts[j]), 32'(exp_code(rows[i].seq, j)));
        xfer(1'b0, ADSC_OFS_RES_BASE + 8'(4 * j), 32'h0);
        chk(q, exp_data(exp_code(rows[i].seq, j)));
      end
      xfer(1'b0, ADSC_OFS_STAT, 32'h0);
      chk({27'h0, q[15:14], q[2:0]}, 32'h10);
      chk(32'(busy_o), 32'h0);
    end
    xfer(1'b1, ADSC_OFS_STAT, 32'hFFFF_FFFF);
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk({27'h0, q[15:14], q[2:0]}, 32'h10);
    xfer(1'b1, 8'h10, 32'hFF);
    xfer(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    run_seq(8'h02, 8'h06);
    wait_done(1);
    repeat (20) @(posedge clk_i);
    chk(32'(starts.size()), 32'h1);
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(32'(q[15]), 32'h1);
    xfer(1'b0, ADSC_OFS_RES_BASE, 32'h0);
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(32'(q[15]), 32'h0);
    // A write to the timing register must start a sequence as well.
    xfer(1'b1, ADSC_OFS_TIMING, 32'h1);
    starts.delete();
    wait_done(1);
    chk(32'(starts.size()), 32'h1);
    lat_r <= 4'h9;
    run_seq(8'h23, 8'h00);
    wait_done(2);
    chk(32'(busy_o), 32'h1);
    run_seq(8'h03, 8'h00);
    chk(32'(n_abort), 32'h1);
    wait_done(1);
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(32'(starts.size()), 32'h4);
    chk(32'(busy_o), 32'h0);
    lat_r <= 4'h2;
    run_seq(8'h13, 8'h01);
    wait_done(1);
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(32'(q[2:0]), 32'h4);
    run_seq(8'h57, 8'h01);
    wait_done(1);
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(32'(q[2:0]), 32'h4);
    xfer(1'b0, ADSC_OFS_RES_BASE + 8'h10, 32'h0);
    chk(q, exp_data(4'h7));
    xfer(1'b0, ADSC_OFS_RES_BASE, 32'h0);
    chk(q, exp_data(4'h3));
    // Reset in the middle of a continuous run must leave everything idle.
    run_seq(8'h23, 8'h00);
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(busy_o), 32'h0);
    xfer(1'b0, ADSC_OFS_SEQ, 32'h0);
    chk(q, {24'h0, ADSC_SEQ_RST});
    xfer(1'b0, ADSC_OFS_STAT, 32'h0);
    chk(q, 32'h0);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_of_test();
  end
endmodule
